// ### fwc_pkg.sv
// constants and types for the peripheral segment firewall check
// Function
// - segment sees identifier shifted left one bit
// - doubled identifier indexes the membership vector
// - nominal id n selects bit 2n
// - violation log records the doubled identifier
// - reset membership vector upper sixteen bits zero
// - nominal ids eight and above denied after reset
package fwc_pkg;
  localparam int FWC_NOM_ID_W = 4;
  localparam int FWC_DBL_ID_W = 5;
  localparam int FWC_MASK_W = 32;
  localparam int FWC_ID_SHIFT = 1;
  localparam int FWC_MAX_NOM_ID = 12;
  // lower half opens ids 0..7, upper half closed
  localparam logic [31:0] FWC_MASK_RST = 32'h0000ffff;
  typedef enum logic [1:0] {FWC_IDLE, FWC_ANSWER} fwc_state_t;
endpackage : fwc_pkg

// ### fwc_lookup_if.sv
// carrier between the firewall check and its membership lookup
`timescale 1ns/100ps
interface fwc_lookup_if #(
  parameter int ID_W = 5,
  parameter int MASK_W = 32
);
  logic [ID_W-1:0] dbl_id;
  logic [MASK_W-1:0] mask;
  logic permit;
  modport check (output dbl_id, output mask, input permit);
  modport lookup (input dbl_id, input mask, output permit);
endinterface : fwc_lookup_if

// ### fwc_lookup.sv
// membership bit selection for one doubled identifier
`timescale 1ns/100ps
module fwc_lookup
  import fwc_pkg::*;
#(
  parameter int ID_W = FWC_DBL_ID_W,
  parameter int MASK_W = FWC_MASK_W
)(
  fwc_lookup_if.lookup lk
);
  logic [MASK_W-1:0] hit_vec;

  // doubled id decode
  // one-hot match per bit, so an id past the mask width never grants
  generate
    for (genvar b = 0; b < MASK_W; b++)
    begin : g_bit
      assign hit_vec[b] = (lk.dbl_id == ID_W'(b)) & lk.mask[b];
    end
  endgenerate

  assign lk.permit = |hit_vec;
endmodule : fwc_lookup

// ### fwc_firewall_check.sv
// access permission check of the peripheral segment firewall
`timescale 1ns/100ps
module fwc_firewall_check
  import fwc_pkg::*;
#(
  parameter int NOM_ID_W = FWC_NOM_ID_W,
  parameter int MASK_W = FWC_MASK_W
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // access request from the interconnect
  input wire logic req_valid_in,
  input wire logic [NOM_ID_W-1:0] req_conn_id_in,
  // membership vector programming
  input wire logic mask_wr_in,
  input wire logic [MASK_W-1:0] mask_wr_data_in,
  // error log clear
  input wire logic log_clear_in,
  // access decision
  output logic resp_valid_out,
  output logic grant_out,
  output logic deny_out,
  // membership vector readback
  output logic [MASK_W-1:0] member_mask_out,
  // violation log
  output logic log_valid_out,
  output logic [NOM_ID_W:0] log_dbl_id_out
);
  localparam int DBL_W = NOM_ID_W + FWC_ID_SHIFT;
  // highest doubled id that the defined initiators reach
  localparam int TOP_DBL_ID = FWC_MAX_NOM_ID << FWC_ID_SHIFT;

  // elaboration checks: refuse widths the lookup cannot serve
  // the highest defined id must find its bit in the mask
  if (MASK_W <= TOP_DBL_ID)
  begin : g_mask_too_narrow
    $error("fwc_firewall_check: membership mask narrower than the doubled id range");
  end
  // the reset pattern is only as wide as the package vector
  if (MASK_W > $bits(FWC_MASK_RST))
  begin : g_mask_too_wide
    $error("fwc_firewall_check: membership mask wider than the reset pattern");
  end
  // the nominal id port must carry every defined initiator
  if (FWC_MAX_NOM_ID >= (1 << NOM_ID_W))
  begin : g_id_too_narrow
    $error("fwc_firewall_check: nominal id port too narrow");
  end
  // the log port and the package agree on the doubled width
  if (DBL_W != FWC_DBL_ID_W)
  begin : g_dbl_mismatch
    $error("fwc_firewall_check: doubled id width differs from the package");
  end

  // request capture and decision state
  fwc_state_t state_r, state_nxt;
  logic [DBL_W-1:0] dbl_id_r;

  // membership vector
  logic [MASK_W-1:0] mask_r;

  // decision pulses
  logic resp_r, grant_r, deny_r;

  // violation log
  logic log_valid_r;
  logic [DBL_W-1:0] log_id_r;

  // next values and named decodes
  wire logic [DBL_W-1:0] shifted_id;
  wire logic [DBL_W-1:0] dbl_id_nxt;
  wire logic [MASK_W-1:0] mask_nxt;
  wire logic answer_now;
  wire logic permit_now;
  wire logic viol_now;
  wire logic log_set;
  wire logic log_load;
  wire logic resp_nxt;
  wire logic grant_nxt;
  wire logic deny_nxt;
  wire logic log_valid_nxt;
  wire logic [DBL_W-1:0] log_id_nxt;

  fwc_lookup_if #(.ID_W(DBL_W), .MASK_W(MASK_W)) lk_if ();

  fwc_lookup #(
    .ID_W(DBL_W),
    .MASK_W(MASK_W)
  ) u_lookup (
    .lk(lk_if.lookup)
  );

  // shift nominal id left one bit
  // doubling is done here so the lookup and log see segment values
  assign shifted_id = {req_conn_id_in, {FWC_ID_SHIFT{1'b0}}};
  // id captured only with a request, held in between
  assign dbl_id_nxt = req_valid_in ? shifted_id : dbl_id_r;

  assign lk_if.dbl_id = dbl_id_r;
  assign lk_if.mask = mask_r;

  // the lookup answers in the cycle after the request was taken
  assign answer_now = (state_r == FWC_ANSWER);
  assign permit_now = lk_if.permit;

  // grant needs the selected bit
  // an unset bit is a violation, never a silent drop
  assign viol_now = answer_now & ~permit_now;
  assign resp_nxt = answer_now;
  assign grant_nxt = answer_now & permit_now;
  assign deny_nxt = viol_now;

  // mask held until reprogrammed
  // a write lands whole; no per-bit update path
  assign mask_nxt = mask_wr_in ? mask_wr_data_in : mask_r;

  // log keeps the first violation
  // a violation in the clear cycle wins, so no event is lost
  assign log_set = viol_now & ~log_valid_r;
  assign log_load = log_set | (viol_now & log_clear_in);
  assign log_valid_nxt = viol_now | (log_valid_r & ~log_clear_in);
  assign log_id_nxt = log_load ? dbl_id_r : log_id_r;

  // request capture then one answer cycle
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FWC_IDLE: state_nxt = req_valid_in ? FWC_ANSWER : FWC_IDLE;
      FWC_ANSWER: state_nxt = req_valid_in ? FWC_ANSWER : FWC_IDLE;
      default: state_nxt = FWC_IDLE;
    endcase
  end

  // decision state
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_r <= FWC_IDLE;
    else
      state_r <= state_nxt;
  end

  // doubled id captured with the request
  // held between requests so the log can still read it
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      dbl_id_r <= '0;
    else
      dbl_id_r <= dbl_id_nxt;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      mask_r <= FWC_MASK_RST[MASK_W-1:0];
    else
      mask_r <= mask_nxt;
  end

  // decision present flag, one cycle per answer
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      resp_r <= 1'b0;
    else
      resp_r <= resp_nxt;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      grant_r <= 1'b0;
    else
      grant_r <= grant_nxt;
  end

  // deny pulse registered
  // kept apart from grant so both stay plain flops
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      deny_r <= 1'b0;
    else
      deny_r <= deny_nxt;
  end

  // sticky violation flag, software clears it
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      log_valid_r <= 1'b0;
    else
      log_valid_r <= log_valid_nxt;
  end

  // log holds doubled id
  // software decodes the doubled value, not the nominal one
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      log_id_r <= '0;
    else
      log_id_r <= log_id_nxt;
  end

  // decision outputs straight from flops
  assign resp_valid_out = resp_r;
  assign grant_out = grant_r;
  assign deny_out = deny_r;

  // readback straight from the mask flops
  assign member_mask_out = mask_r;

  // log outputs straight from flops
  assign log_valid_out = log_valid_r;
  assign log_dbl_id_out = log_id_r;
endmodule : fwc_firewall_check

// ### fwc_firewall_check_asserts.sv
// port assertions for the firewall check
`timescale 1ns/100ps
module fwc_firewall_check_asserts
  import fwc_pkg::*;
(
  // watched ports
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic req_valid_in,
  input wire logic [3:0] req_conn_id_in,
  input wire logic mask_wr_in,
  input wire logic [31:0] mask_wr_data_in,
  input wire logic log_clear_in,
  input wire logic resp_valid_out,
  input wire logic grant_out,
  input wire logic deny_out,
  input wire logic [31:0] member_mask_out,
  input wire logic log_valid_out,
  input wire logic [4:0] log_dbl_id_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [3:0] id_d_r;
  // id kept one cycle so the lookup edge can index with it
  always_ff @(posedge clk_in)
    id_d_r <= req_conn_id_in;
  property p_lat; req_valid_in |-> ##2 resp_valid_out; endproperty
  a_lat: assert property (p_lat) else $error("decision late");
  property p_grant;
    resp_valid_out |-> grant_out == $past(member_mask_out[{id_d_r, 1'b0}]);
  endproperty
  a_grant: assert property (p_grant) else $error("wrong bit used");
  property p_one;
    (grant_out | deny_out) == resp_valid_out && !(grant_out && deny_out);
  endproperty
  a_one: assert property (p_one) else $error("grant and deny clash");
  property p_log;
    deny_out && !$past(log_valid_out) |-> log_valid_out && log_dbl_id_out == {$past(id_d_r), 1'b0};
  endproperty
  a_log: assert property (p_log) else $error("bad logged id");
  property p_keep;
    log_valid_out && !log_clear_in |=> log_valid_out && $stable(log_dbl_id_out);
  endproperty
  a_keep: assert property (p_keep) else $error("log overwritten");
  property p_rst; $rose(arst_n_in) |-> member_mask_out == FWC_MASK_RST; endproperty
  a_rst: assert property (p_rst) else $error("bad reset mask");
  property p_wr; mask_wr_in |=> member_mask_out == $past(mask_wr_data_in); endproperty
  a_wr: assert property (p_wr) else $error("mask not written");
endmodule : fwc_firewall_check_asserts

// ### fwc_initiator_model.sv
// interconnect initiator issuing single accesses
`timescale 1ns/100ps
module fwc_initiator_model (
  // request side
  input wire logic clk_in,
  output logic req_valid_out,
  output logic [3:0] req_conn_id_out
);
  initial
  begin
    req_valid_out = 1'b0;
    req_conn_id_out = 4'h0;
  end
  task automatic access(input logic [3:0] id);
    @(negedge clk_in);
    req_valid_out = 1'b1;
    req_conn_id_out = id;
    @(negedge clk_in);
    req_valid_out = 1'b0;
    req_conn_id_out = ~id; // stale id must not be trusted
    // return while the one-cycle decision pulse still stands
    @(negedge clk_in);
  endtask : access
endmodule : fwc_initiator_model

// ### fwc_firewall_check_tb_top.sv
// self-checking bench for the firewall check
`timescale 1ns/100ps
module fwc_firewall_check_tb_top;
  import fwc_pkg::*;
  logic clk_in, arst_n_in, req_valid_in, mask_wr_in, log_clear_in;
  logic resp_valid_out, grant_out, deny_out, log_valid_out;
  logic [3:0] req_conn_id_in;
  logic [4:0] log_dbl_id_out;
  logic [31:0] mask_wr_data_in, member_mask_out;
  int err_total, comparisons, cyc;
  fwc_initiator_model i_fwc_initiator_model (.clk_in(clk_in), .req_valid_out(req_valid_in),
    .req_conn_id_out(req_conn_id_in));
  fwc_firewall_check i_fwc_firewall_check (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .req_valid_in(req_valid_in),
    .req_conn_id_in(req_conn_id_in),
    .mask_wr_in(mask_wr_in),
    .mask_wr_data_in(mask_wr_data_in),
    .log_clear_in(log_clear_in),
    .resp_valid_out(resp_valid_out),
    .grant_out(grant_out),
    .deny_out(deny_out),
    .member_mask_out(member_mask_out),
    .log_valid_out(log_valid_out),
    .log_dbl_id_out(log_dbl_id_out)
  );
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task acc(input logic [3:0] id, input logic g);
    i_fwc_initiator_model.access(id);
    chk({31'h0, resp_valid_out}, 32'h1);
    chk({31'h0, grant_out}, {31'h0, g});
    chk({31'h0, deny_out}, {31'h0, !g});
  endtask : acc
  task t_scan;
    chk(member_mask_out, FWC_MASK_RST);
    for (int i = 0; i <= FWC_MAX_NOM_ID; i++)
      acc(4'(i), i < 8);
    chk({31'h0, log_valid_out}, 32'h1);
    chk({27'h0, log_dbl_id_out}, 32'h10);
    $display("scan done");
  endtask : t_scan
  task t_prog;
    @(negedge clk_in);
    mask_wr_in = 1'b1;
    mask_wr_data_in = 32'h01000000;
    log_clear_in = 1'b1;
    @(negedge clk_in);
    mask_wr_in = 1'b0;
    log_clear_in = 1'b0;
    chk(member_mask_out, 32'h01000000);
    chk({31'h0, log_valid_out}, 32'h0);
    acc(4'hc, 1'b1);
    acc(4'h9, 1'b0);
    chk({27'h0, log_dbl_id_out}, 32'h12);
    $display("program done");
  endtask : t_prog
  // violation lands in the very cycle the log is cleared
  task t_clash;
    fork
      acc(4'ha, 1'b0);
      begin
        repeat (2) @(negedge clk_in);
        log_clear_in = 1'b1;
        @(negedge clk_in);
        log_clear_in = 1'b0;
      end
    join
    chk({31'h0, log_valid_out}, 32'h1);
    chk({27'h0, log_dbl_id_out}, 32'h14);
    $display("clash done");
  endtask : t_clash
  // free-running clock, 4 ns period
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // hang guard well above the expected run
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    arst_n_in = 1'b0;
    mask_wr_in = 1'b0;
    mask_wr_data_in = 32'h0;
    log_clear_in = 1'b0;
    repeat (20) @(negedge clk_in);
    arst_n_in = 1'b1;
    t_scan();
    t_prog();
    t_clash();
    conclude();
  end
endmodule : fwc_firewall_check_tb_top
bind fwc_firewall_check fwc_firewall_check_asserts i_fwc_firewall_check_asserts (
  .clk_in(clk_in),
  .arst_n_in(arst_n_in),
  .req_valid_in(req_valid_in),
  .req_conn_id_in(req_conn_id_in),
  .mask_wr_in(mask_wr_in),
  .mask_wr_data_in(mask_wr_data_in),
  .log_clear_in(log_clear_in),
  .resp_valid_out(resp_valid_out),
  .grant_out(grant_out),
  .deny_out(deny_out),
  .member_mask_out(member_mask_out),
  .log_valid_out(log_valid_out),
  .log_dbl_id_out(log_dbl_id_out)
);
